// file: src/supervisor_regs.svh
/*
 * Constants of the two-wire slave access block: slave byte layout,
 * register addresses, write cycle timing and the last bit count.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// --------------------------------------------------------------
// Slave address byte layout
// --------------------------------------------------------------
`define SLV_TYPE_MSB      7
`define SLV_TYPE_LSB      5
`define SLV_TYPE_ID       3'h6    // Arbitrary type identifier value
`define SLV_SPACE_BIT     4
`define SLV_ZERO_MSB      3
`define SLV_ZERO_LSB      2
`define SLV_AMSB_BIT      1
`define SLV_DIR_BIT       0

// --------------------------------------------------------------
// Register space
// --------------------------------------------------------------
`define CTRL_CFG_ADDR     9'h1FF
`define FAULT_CAP_ADDR    9'h0FF
`define CTRL_CFG_RESET    8'h00
`define FAULT_CAP_RESET   8'h00

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define CLK_MHZ           100
`define WRITE_CYCLE_MS    5
`define WRITE_CYCLE_CYC   (`WRITE_CYCLE_MS * 1000 * `CLK_MHZ)
`define BIT_COUNT_LAST    4'h8

`endif

// file: src/supervisor_pkg.sv
/*
 * Types shared by the two-wire slave access block.
 * Assumes supervisor_regs.svh on the include path.
 */
`include "supervisor_regs.svh"

package supervisor_pkg;

	// Protocol phase of the slave
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_SLAVE = 7'h02,
		ST_WADDR = 7'h04,
		ST_WDATA = 7'h08,
		ST_READ  = 7'h10,
		ST_BUSY  = 7'h20,
		ST_IGN   = 7'h40
	} phase_t;

endpackage

// file: src/byte_fifo.sv
/*
 * Small valid/ready FIFO with registered read data.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             ref_clk_i,
	input  wire logic             rst_n_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	// Flush
	input  wire logic             flush_i
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} fifo_state_t;

	fifo_state_t st_reg;
	fifo_state_t st_next;

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	// Output word is held in a register so the drain sees a flop
	always_comb
	begin
		logic push;
		logic pop;
		st_next = st_reg;
		push = in_valid_i && (st_reg.cnt != (AW+1)'(DEPTH));
		pop = (!st_reg.ov || out_ready_i) && (st_reg.cnt != '0);
		if (st_reg.ov && out_ready_i)
			st_next.ov = 1'b0;
		if (push)
		begin
			st_next.mem[st_reg.wr] = in_data_i;
			st_next.wr = st_reg.wr + 1'b1;
		end
		if (pop)
		begin
			st_next.od = st_reg.mem[st_reg.rd];
			st_next.ov = 1'b1;
			st_next.rd = st_reg.rd + 1'b1;
		end
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_i)
		begin
			st_next.wr = '0;
			st_next.rd = '0;
			st_next.cnt = '0;
			st_next.ov = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign in_ready_o = (st_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = st_reg.ov;
	assign out_data_o = st_reg.od;

endmodule

`default_nettype wire

// file: src/supervisor_serial_slave_access.sv
/*
 * Two-wire slave access of a supply supervisor: byte writes with a
 * timed nonvolatile write cycle, acknowledge polling, current address,
 * random, sequential and set-address reads, and two registers.
 * Assumes the bus pins are open drain, pulled up outside, and that the
 * storage array sits outside behind the store and fetch ports. Read
 * bytes are prefetched through a small FIFO; a byte not yet fetched when it is due ends the read.
 */
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"

module supervisor_serial_slave_access
	import supervisor_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLE_CYC,
	parameter int          ADDR_W       = 9,
	parameter int          FIFO_DEPTH   = 4
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_n_i,
	// Two-wire bus pins
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	// Protection
	input  wire logic [ADDR_W-1:0] prot_lo_i,
	input  wire logic [ADDR_W-1:0] prot_hi_i,
	input  wire logic              prot_en_i,
	// Array store port
	output logic                   store_o,
	output logic [ADDR_W-1:0]      store_addr_o,
	output logic [7:0]             store_data_o,
	// Array fetch port
	output logic                   fetch_valid_o,
	input  wire logic              fetch_ready_i,
	output logic [ADDR_W-1:0]      fetch_addr_o,
	input  wire logic              fetch_rvalid_i,
	input  wire logic [7:0]        fetch_rdata_i,
	// Status and register contents
	output logic                   busy_o,
	output logic [7:0]             ctrl_cfg_o,
	output logic [7:0]             fault_cap_o
);

	typedef struct packed {
		logic [1:0]        scl_s;
		logic [1:0]        sda_s;
		logic              scl_d;
		logic              sda_d;
		phase_t            ph;
		logic [3:0]        bitc;
		logic [7:0]        sh;
		logic              ack_ph;
		logic              drv_low;
		logic              rd_dir;
		logic              reg_sp;
		logic              amsb;
		logic [ADDR_W-1:0] waddr;
		logic [ADDR_W-1:0] acnt;
		logic [ADDR_W-1:0] facnt;
		logic              pend_wr;
		logic [7:0]        pend_data;
		logic              nacked;
		logic [31:0]       wcnt;
		logic              store;
		logic [ADDR_W-1:0] store_addr;
		logic [7:0]        store_data;
		logic              fvalid;
		logic              need;
		logic              tx;
		logic [7:0]        ctrl_cfg;
		logic [7:0]        fault_cap;
	} slave_state_t;

	slave_state_t s_reg;
	slave_state_t s_next;

	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic       fifo_pop;
	logic       fifo_flush;
	logic       fifo_push;
	logic [7:0] fifo_push_data;

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	// Full address of an array or register access from the slave byte and word
	function automatic logic [ADDR_W-1:0] full_addr(input logic msb, input logic [7:0] lo);
		full_addr = {msb, lo};
	endfunction

	function automatic logic in_prot(input logic [ADDR_W-1:0] a, input logic en,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		in_prot = en && (a >= lo) && (a <= hi);
	endfunction

	// -------------------------------------------------------------
	// Read data prefetch FIFO
	// -------------------------------------------------------------
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) byte_fifo_inst (
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_push_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_out_data),
		.flush_i     (fifo_flush)
	);

	// Register space reads bypass the array and enter the FIFO directly
	assign fifo_push = s_reg.reg_sp ? (s_reg.need && s_reg.tx) : fetch_rvalid_i;
	assign fifo_push_data = !s_reg.reg_sp ? fetch_rdata_i :
		(s_reg.facnt == `CTRL_CFG_ADDR) ? s_reg.ctrl_cfg :
		(s_reg.facnt == `FAULT_CAP_ADDR) ? s_reg.fault_cap : 8'h00;

	// -------------------------------------------------------------
	// Bus protocol engine
	// -------------------------------------------------------------
	// Pins are asynchronous, so both pass two flops before any use
	always_comb
	begin
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic [7:0] sb;
		logic [ADDR_W-1:0] a;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		sb = 8'h00;
		a = '0;
		s_next = s_reg;
		fifo_pop = 1'b0;
		fifo_flush = 1'b0;
		s_next.scl_s = {s_reg.scl_s[0], scl_i};
		s_next.sda_s = {s_reg.sda_s[0], sda_i};
		s_next.scl_d = s_reg.scl_s[1];
		s_next.sda_d = s_reg.sda_s[1];
		s_next.store = 1'b0;
		scl_rise = s_reg.scl_s[1] && !s_reg.scl_d;
		scl_fall = !s_reg.scl_s[1] && s_reg.scl_d;
		start_c = s_reg.scl_s[1] && s_reg.scl_d && !s_reg.sda_s[1] && s_reg.sda_d;
		stop_c = s_reg.scl_s[1] && s_reg.scl_d && s_reg.sda_s[1] && !s_reg.sda_d;

		// Array prefetch request handshake
		if (s_reg.fvalid && fetch_ready_i)
		begin
			s_next.fvalid = 1'b0;
			s_next.facnt = s_reg.facnt + 1'b1;
		end
		if (s_reg.need && s_reg.tx && s_reg.reg_sp)
			s_next.need = 1'b0;
		else if (s_reg.need && s_reg.tx && !s_reg.fvalid && fifo_in_ready)
		begin
			s_next.fvalid = 1'b1;
			s_next.need = 1'b0;
		end

		if (s_reg.ph == ST_BUSY)
		begin
			// Inputs are ignored until the cycle count expires
			s_next.drv_low = 1'b0;
			if (s_reg.wcnt == 32'h0)
				s_next.ph = ST_IDLE;
			else
				s_next.wcnt = s_reg.wcnt - 32'h1;
		end
		else if (stop_c)
		begin
			s_next.drv_low = 1'b0;
			s_next.tx = 1'b0;
			fifo_flush = 1'b1;
			s_next.need = 1'b0;
			s_next.fvalid = 1'b0;
			if (s_reg.pend_wr && s_reg.bitc <= 4'h1 && !s_reg.ack_ph)
			begin
				// Full byte plus acknowledge: commit; the stop's own clock rise counts one bit
				s_next.pend_wr = 1'b0;
				a = s_reg.waddr;
				if (s_reg.reg_sp && a == `CTRL_CFG_ADDR)
					s_next.ctrl_cfg = s_reg.pend_data;
				else if (s_reg.reg_sp && a == `FAULT_CAP_ADDR)
					s_next.fault_cap = s_reg.pend_data;
				else if (!s_reg.reg_sp)
				begin
					s_next.store = 1'b1;
					s_next.store_addr = a;
					s_next.store_data = s_reg.pend_data;
				end
				s_next.acnt = a + 1'b1;
				s_next.wcnt = WRITE_CYCLES - 32'h1;
				s_next.ph = ST_BUSY;
			end
			else
			begin
				// Early or mid-byte stop drops the pending write
				s_next.pend_wr = 1'b0;
				s_next.ph = ST_IDLE;
			end
		end
		else if (start_c)
		begin
			s_next.ph = ST_SLAVE;
			s_next.bitc = 4'h0;
			s_next.ack_ph = 1'b0;
			s_next.drv_low = 1'b0;
			s_next.tx = 1'b0;
			s_next.pend_wr = 1'b0;
			fifo_flush = 1'b1;
			s_next.need = 1'b0;
			s_next.fvalid = 1'b0;
		end
		else if (s_reg.ph != ST_IDLE && s_reg.ph != ST_IGN)
		begin
			if (scl_rise && !s_reg.ack_ph)
			begin
				s_next.sh = {s_reg.sh[6:0], s_reg.sda_s[1]};
				s_next.bitc = s_reg.bitc + 4'h1;
			end
			else if (scl_rise && s_reg.ack_ph && s_reg.tx)
			begin
				// Master acknowledge asks for the next byte
				if (s_reg.sda_s[1])
					s_next.ph = ST_IGN;
				else
					s_next.acnt = s_reg.acnt + 1'b1;
			end
			if (scl_fall && s_reg.ack_ph)
			begin
				// End of ninth clock
				s_next.ack_ph = 1'b0;
				s_next.drv_low = 1'b0;
				s_next.bitc = 4'h0;
				if (s_reg.tx && s_reg.ph != ST_IGN && s_next.ph != ST_IGN)
				begin
					s_next.sh = fifo_out_data;
					fifo_pop = 1'b1;
					s_next.drv_low = !fifo_out_data[7];
					s_next.need = 1'b1;
				end
			end
			else if (scl_fall && s_reg.tx && s_reg.bitc != 4'h0 && s_reg.bitc != `BIT_COUNT_LAST)
			begin
				s_next.drv_low = !s_reg.sh[7];             // Shift keeps the next bit on top
			end
			else if (scl_fall && s_reg.bitc == `BIT_COUNT_LAST)
			begin
				s_next.ack_ph = 1'b1;
				s_next.drv_low = 1'b0;
				sb = s_reg.sh;
				unique case (s_reg.ph)
					ST_SLAVE:
					begin
						if (sb[`SLV_TYPE_MSB:`SLV_TYPE_LSB] == `SLV_TYPE_ID
							&& sb[`SLV_ZERO_MSB:`SLV_ZERO_LSB] == 2'b00)
						begin
							s_next.drv_low = 1'b1;
							s_next.reg_sp = sb[`SLV_SPACE_BIT];
							s_next.amsb = sb[`SLV_AMSB_BIT];
							s_next.rd_dir = sb[`SLV_DIR_BIT];
							if (sb[`SLV_DIR_BIT])
							begin
								// Current address read from the counter
								s_next.tx = 1'b1;
								s_next.ph = ST_READ;
								s_next.facnt = s_reg.acnt;
								s_next.need = 1'b1;
							end
							else
								s_next.ph = ST_WADDR;
						end
						else
							s_next.ph = ST_IGN;
					end
					ST_WADDR:
					begin
						a = full_addr(s_reg.amsb, sb);
						s_next.waddr = a;
						s_next.acnt = a;
						s_next.drv_low = 1'b1;
						s_next.ph = ST_WDATA;
					end
					ST_WDATA:
					begin
						if (s_reg.pend_wr || (!s_reg.reg_sp &&
							in_prot(s_reg.waddr, prot_en_i, prot_lo_i, prot_hi_i)))
						begin
							// Protected or second byte: no acknowledge
							s_next.drv_low = 1'b0;
							s_next.pend_wr = 1'b0;
							s_next.ph = ST_IGN;
						end
						else
						begin
							s_next.drv_low = 1'b1;
							s_next.pend_wr = 1'b1;
							s_next.pend_data = sb;
						end
					end
					ST_READ:
						s_next.drv_low = 1'b0;
					default:
						s_next.ph = ST_IGN;
				endcase
			end
			// Drop the read if no byte is ready at the fall that ends an acknowledge clock
			if (s_reg.ph == ST_READ && s_reg.tx && s_reg.ack_ph && scl_fall && !fifo_out_valid)
				s_next.ph = ST_IGN;
		end
	end

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_reg <= '0;
			s_reg.scl_s <= 2'b11;
			s_reg.sda_s <= 2'b11;
			s_reg.scl_d <= 1'b1;
			s_reg.sda_d <= 1'b1;
			s_reg.ph <= ST_IDLE;
			s_reg.ctrl_cfg <= `CTRL_CFG_RESET;
			s_reg.fault_cap <= `FAULT_CAP_RESET;
		end
		else
			s_reg <= s_next;
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	// Open drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_o = s_reg.drv_low;
	assign store_o = s_reg.store;
	assign store_addr_o = s_reg.store_addr;
	assign store_data_o = s_reg.store_data;
	assign fetch_valid_o = s_reg.fvalid;
	assign fetch_addr_o = s_reg.facnt;
	assign busy_o = (s_reg.ph == ST_BUSY);
	assign ctrl_cfg_o = s_reg.ctrl_cfg;
	assign fault_cap_o = s_reg.fault_cap;

endmodule

`default_nettype wire

// file: tb/supervisor_serial_slave_access_props.sv
/*
 * Checker for the two-wire slave access block, bound to its ports.
 * Assumes the top module's ports and parameters as declared in src.
 */
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"

module supervisor_serial_slave_access_props #(
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLE_CYC,
	parameter int          ADDR_W       = 9
) (
	// Clock, reset and bus
	input  wire logic              ref_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	input  wire logic              sda_oe_o,
	// Protection and array
	input  wire logic [ADDR_W-1:0] prot_lo_i,
	input  wire logic [ADDR_W-1:0] prot_hi_i,
	input  wire logic              prot_en_i,
	input  wire logic              store_o,
	input  wire logic [ADDR_W-1:0] store_addr_o,
	input  wire logic              fetch_valid_o,
	input  wire logic              fetch_ready_i,
	input  wire logic [ADDR_W-1:0] fetch_addr_o,
	// Status and registers
	input  wire logic              busy_o,
	input  wire logic [7:0]        ctrl_cfg_o,
	input  wire logic [7:0]        fault_cap_o
);
	int unsigned busy_cnt;

	// Length of the current busy stretch, checked at its end
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
		if (!rst_n_i)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_o ? busy_cnt + 1 : 0;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_BUSY_RELEASED: assert property (busy_o |-> !sda_oe_o)
		else $error("bus driven during write cycle");
	AST_STORE_BUSY: assert property (store_o |=> busy_o)
		else $error("write cycle not started after store");
	AST_BUSY_LEN: assert property ($fell(busy_o) |-> busy_cnt == WRITE_CYCLES)
		else $error("write cycle length wrong");
	AST_STORE_ONCE: assert property (store_o |=> !store_o)
		else $error("store longer than one cycle");
	AST_NO_STORE_BUSY: assert property (store_o |-> !$past(busy_o))
		else $error("store during write cycle");
	AST_STORE_PROT: assert property (store_o && prot_en_i |->
		!(store_addr_o >= prot_lo_i && store_addr_o <= prot_hi_i))
		else $error("store into protected range");
	AST_FETCH_HOLD: assert property (fetch_valid_o && !fetch_ready_i |=>
		fetch_valid_o && $stable(fetch_addr_o))
		else $error("fetch request dropped or changed");
	AST_REGS_BUSY: assert property (busy_o && $past(busy_o) |->
		$stable(ctrl_cfg_o) && $stable(fault_cap_o))
		else $error("register changed during write cycle");
	AST_STORE_AT_STOP: assert property (store_o |-> scl_i && sda_i)
		else $error("store without a stop");
endmodule

bind supervisor_serial_slave_access supervisor_serial_slave_access_props #(
	.WRITE_CYCLES(WRITE_CYCLES), .ADDR_W(ADDR_W)) props_inst (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
	.prot_lo_i(prot_lo_i), .prot_hi_i(prot_hi_i), .prot_en_i(prot_en_i), .store_o(store_o),
	.store_addr_o(store_addr_o), .fetch_valid_o(fetch_valid_o), .fetch_ready_i(fetch_ready_i),
	.fetch_addr_o(fetch_addr_o), .busy_o(busy_o), .ctrl_cfg_o(ctrl_cfg_o), .fault_cap_o(fault_cap_o));

`default_nettype wire

// file: tb/master_model.sv
/*
 * Behavioural two-wire bus master: bit, byte, start and stop tasks.
 * Assumes an 80 ns bus clock, open-drain data resolved by the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module master_model (
	// System clock and resolved data line
	input  wire logic ref_clk_i,
	input  wire logic sda_i,
	// Driven bus lines, released means high
	output logic      scl_o,
	output logic      sda_o
);
	// Bus idles released; clock stands high outside frames
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// Data changes while clock low, sampled late in the high half
	task automatic xbit(input logic b, output logic r);
		tick(1);
		sda_o <= b;
		tick(3);
		scl_o <= 1'b1;
		tick(3);
		r = sda_i;
		tick(1);
		scl_o <= 1'b0;
	endtask

	// Also serves as repeated start and as a completion poll
	task automatic start();
		tick(1);
		sda_o <= 1'b1;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b0;
	endtask

	task automatic stop();
		tick(1);
		sda_o <= 1'b0;
		tick(3);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b1;
		tick(4);
	endtask

	// Eight bits out, then the slave's acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(b[i], r);
		xbit(1'b1, r);
		ack = !r;
	endtask

	// Eight bits in; a withheld acknowledge ends the read
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, d[i]);
		xbit(!mack, r);
	endtask
endmodule

`default_nettype wire

// file: tb/supervisor_serial_slave_access_tb_top.sv
/*
 * Self-checking bench: bus master model, array memory with stalls.
 * Assumes the design, package and checker compiled beforehand.
 */
`timescale 1ns/1ps
`default_nettype none

module supervisor_serial_slave_access_tb_top;
	import supervisor_pkg::*;
	localparam int WC = 200; // Long enough that a poll falls wholly inside the cycle
	logic       ref_clk_i = 1'b0, rst_n_i = 1'b0, prot_en_i = 1'b0;
	logic       fetch_ready_i = 1'b1, fetch_rvalid_i = 1'b0;
	logic [8:0] prot_lo_i = 9'h100, prot_hi_i = 9'h10F, store_addr_o, fetch_addr_o, st_addr;
	logic [7:0] fetch_rdata_i = 8'h00, store_data_o, ctrl_cfg_o, fault_cap_o, st_data;
	logic       scl, sda_m, sda_o, sda_oe_o, store_o, fetch_valid_o, busy_o, a, b, c;
	logic [7:0] mem [512];
	logic [7:0] rb [4];
	int         n_mismatch = 0, num_checks = 0, st_cnt = 0;
	wire logic  sda = (sda_oe_o ? sda_o : 1'b1) & sda_m;

	initial forever #5 ref_clk_i = ~ref_clk_i;

	supervisor_serial_slave_access #(.WRITE_CYCLES(WC)) supervisor_serial_slave_access_inst (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .prot_lo_i(prot_lo_i), .prot_hi_i(prot_hi_i), .prot_en_i(prot_en_i),
		.store_o(store_o), .store_addr_o(store_addr_o), .store_data_o(store_data_o),
		.fetch_valid_o(fetch_valid_o), .fetch_ready_i(fetch_ready_i), .fetch_addr_o(fetch_addr_o),
		.fetch_rvalid_i(fetch_rvalid_i), .fetch_rdata_i(fetch_rdata_i), .busy_o(busy_o),
		.ctrl_cfg_o(ctrl_cfg_o), .fault_cap_o(fault_cap_o));
	master_model master_model_inst (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

	// Array model: stalls every other cycle, stale data inverted
	always @(posedge ref_clk_i)
	begin
		fetch_ready_i <= ~fetch_ready_i;
		fetch_rvalid_i <= fetch_valid_o & fetch_ready_i;
		fetch_rdata_i <= (fetch_valid_o & fetch_ready_i) ? mem[fetch_addr_o] : ~fetch_rdata_i;
		if (store_o)
		begin
			mem[store_addr_o] <= store_data_o;
			st_addr <= store_addr_o;
			st_data <= store_data_o;
			st_cnt <= st_cnt + 1;
		end
	end

	task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] sb, input logic [7:0] wa, input logic [7:0] d);
		master_model_inst.start();
		master_model_inst.wbyte(sb, a);
		master_model_inst.wbyte(wa, b);
		master_model_inst.wbyte(d, c);
		master_model_inst.stop();
	endtask

	// Optional dummy write, then n bytes, last one not acknowledged
	task automatic rd(input logic [7:0] sb, input logic [7:0] wa, input logic rnd, input int n);
		if (rnd)
		begin
			master_model_inst.start();
			master_model_inst.wbyte({sb[7:1], 1'b0}, b);
			master_model_inst.wbyte(wa, b);
		end
		master_model_inst.start();
		master_model_inst.wbyte(sb, a);
		chk("read slave ack", 9'h001, 9'(a));
		for (int i = 0; i < n; i++)
			master_model_inst.rbyte(i < n - 1, rb[i]);
		master_model_inst.stop();
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog: whole sequence needs well under 100 us
	initial
	begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 512; i++)
			mem[i] = 8'(i) ^ 8'h3C;
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		prot_en_i <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		chk("ctrl reset", 9'h000, 9'(ctrl_cfg_o));
		chk("fault reset", 9'h000, 9'(fault_cap_o));
		wr(8'hC0, 8'h23, 8'h5A);
		chk("write acks", 9'h007, 9'({a, b, c}));
		repeat (2) @(posedge ref_clk_i);
		chk("store addr", 9'h023, st_addr);
		chk("store data", 9'h05A, 9'(st_data));
		chk("busy", 9'h001, 9'(busy_o));
		master_model_inst.start();
		master_model_inst.wbyte(8'hC0, a);
		chk("poll ack busy", 9'h000, 9'(a));
		repeat (WC + 8) @(posedge ref_clk_i);
		rd(8'hC1, 8'h00, 1'b0, 1);
		chk("read after write", 9'(8'h24 ^ 8'h3C), 9'(rb[0]));
		$display("test write_poll done");
		rd(8'hC3, 8'hFE, 1'b1, 3);
		chk("seq 1FE", 9'(8'hFE ^ 8'h3C), 9'(rb[0]));
		chk("seq 1FF", 9'(8'hFF ^ 8'h3C), 9'(rb[1]));
		chk("seq wrap", 9'(8'h00 ^ 8'h3C), 9'(rb[2]));
		rd(8'hC1, 8'h00, 1'b0, 1);
		chk("counter after seq", 9'(8'h01 ^ 8'h3C), 9'(rb[0]));
		$display("test seq_read done");
		master_model_inst.start();
		master_model_inst.wbyte(8'hC0, a);
		master_model_inst.wbyte(8'h50, b);
		master_model_inst.stop();
		chk("set addr no busy", 9'h000, 9'(busy_o));
		rd(8'hC1, 8'h00, 1'b0, 1);
		chk("set addr read", 9'(8'h50 ^ 8'h3C), 9'(rb[0]));
		master_model_inst.start();
		master_model_inst.wbyte(8'hC0, a);
		master_model_inst.wbyte(8'h33, b);
		for (int i = 0; i < 4; i++)
			master_model_inst.xbit(1'b0, c);
		master_model_inst.stop();
		chk("mid byte stop", 9'h001, 9'(st_cnt));
		wr(8'hC2, 8'h05, 8'h77);
		chk("protected nack", 9'h000, 9'(c));
		chk("protected kept", 9'h001, 9'(st_cnt));
		$display("test aborts done");
		wr(8'hD2, 8'hFF, 8'hC3);
		repeat (WC + 8) @(posedge ref_clk_i);
		chk("ctrl write", 9'h0C3, 9'(ctrl_cfg_o));
		wr(8'hD0, 8'hFF, 8'h96);
		repeat (WC + 8) @(posedge ref_clk_i);
		chk("fault write", 9'h096, 9'(fault_cap_o));
		rd(8'hD3, 8'hFF, 1'b1, 1);
		chk("ctrl read", 9'h0C3, 9'(rb[0]));
		rd(8'hD1, 8'hFF, 1'b1, 1);
		chk("fault read", 9'h096, 9'(rb[0]));
		master_model_inst.start();
		master_model_inst.wbyte(8'h60, a);
		master_model_inst.stop();
		chk("wrong type nack", 9'h000, 9'(a));
		$display("test registers done");
		report_and_stop();
	end
endmodule

`default_nettype wire
